//--- hdl/fea_pkg.sv
/*
 * constants and types for the extended address former of a serial flash.
 * assumes a single 50 MHz system clock; the link runs far slower.
 */
package fea_pkg;

    // command opcodes seen on the serial input
    localparam logic [7:0] OP_READ_3B = 8'h03;
    localparam logic [7:0] OP_READ_4B = 8'h13;
    localparam logic [7:0] OP_OTP_READ = 8'h4b;
    localparam logic [7:0] OP_BANK_WRITE = 8'h17;
    localparam logic [7:0] OP_BANK_READ = 8'h16;
    localparam logic [7:0] OP_READ_ID = 8'h9f;

    // bank register layout and reset value
    localparam int BANK_EXT_BIT = 7;
    localparam int BANK_HI_MSB = 6;
    localparam logic [7:0] BANK_RESET = 8'h00;

    // last bit index of each serial field, counted from zero
    localparam logic [5:0] LAST_BIT_BYTE = 6'h07;
    localparam logic [5:0] LAST_BIT_3B = 6'h17;
    localparam logic [5:0] LAST_BIT_4B = 6'h1f;

    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_BANK_WR = 3'b010,
        ST_BANK_RD = 3'b011,
        ST_REST = 3'b100
    } fea_state_type;

    typedef enum logic [1:0] {
        SPACE_MAIN = 2'b00,
        SPACE_ID = 2'b01,
        SPACE_OTP = 2'b10
    } fea_space_type;

endpackage : fea_pkg

//--- hdl/fea_addr.sv
/*
 * serial command front end that forms 32-bit addresses from three- or
 * four-byte address fields, with a command-loadable bank register.
 * assumes spi mode 0 from the host (sample on rising sck) and an sck
 * at least eight times slower than clk; all pins are asynchronous.
 */
// Summary of operation
// - addresses handed to the array side are a full 32 bits wide.
// - a three-byte field reaches only 16 Mbytes, so upper bits come from the bank.
// - legacy commands still take a three-byte address by default.
// - a bank register written by a host command supplies the upper bits.
// - the top bank bit makes the legacy read command take four address bytes; no other command depends on it.
// - the dedicated four-byte commands always take four address bytes.
// - reset clears the bank register and so returns to three-byte mode.
// - the small variant drops bits 31 to 24 for main array accesses.
// - accesses to other spaces keep all 32 address bits.
// - the identification command selects its own read-only space.
// - the one-time-programmable space is reached by its own command.
`timescale 1ns/1ps
module fea_addr
    import fea_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // density strap, high for the small variant
    input wire logic small_density,
    // array side
    output logic addr_valid,
    output logic [31:0] eff_addr,
    output logic [1:0] addr_space,
    output logic [7:0] bank_reg
);

    // field width for an opcode; used at decode and nowhere cheaper
    function automatic logic [5:0] last_addr_bit(input logic [7:0] op,
                                                 input logic ext);
        if (op == OP_READ_3B) begin
            last_addr_bit = ext ? LAST_BIT_4B : LAST_BIT_3B;
        end else begin
            last_addr_bit = LAST_BIT_4B;
        end
    endfunction : last_addr_bit

    // reset release through two flops
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // pin synchronisers; stage one feeds only stage two
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic sck_last;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= 4'hb;
            pin_sync <= 4'hb;
            sck_last <= 1'b0;
        end else begin
            pin_meta <= {small_density, sck, cs_n, si};
            pin_sync <= pin_meta;
            sck_last <= pin_sync[2];
        end
    end

    logic si_s;
    logic cs_hi;
    logic sck_s;
    logic small_s;
    logic sck_rise;
    logic sck_fall;

    assign si_s = pin_sync[0];
    assign cs_hi = pin_sync[1];
    assign sck_s = pin_sync[2];
    assign small_s = pin_sync[3];
    assign sck_rise = sck_s & ~sck_last;
    assign sck_fall = ~sck_s & sck_last;

    // sequencer state
    fea_state_type state;
    fea_state_type next_state;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit_cnt;
    logic [31:0] shift_in;
    logic [31:0] next_shift_in;
    logic [7:0] shift_out;
    logic [7:0] next_shift_out;
    logic [5:0] addr_last;
    logic [5:0] next_addr_last;
    logic [1:0] next_addr_space;
    logic [7:0] next_bank_reg;
    logic next_addr_valid;
    logic [31:0] next_eff_addr;
    logic next_so;
    logic next_so_oe_n;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_addr_last = addr_last;
        next_addr_space = addr_space;
        next_bank_reg = bank_reg;
        next_addr_valid = 1'b0;
        next_eff_addr = eff_addr;
        next_so = so;
        next_so_oe_n = so_oe_n;
        if (cs_hi) begin
            // deselect ends any command, even a partial one
            next_state = ST_CMD;
            next_bit_cnt = 6'h00;
            next_so_oe_n = 1'b1;
        end else if (sck_rise) begin
            next_shift_in = {shift_in[30:0], si_s};
            next_bit_cnt = bit_cnt + 6'h01;
            case (state)
                ST_CMD: begin
                    if (bit_cnt == LAST_BIT_BYTE) begin
                        next_bit_cnt = 6'h00;
                        next_addr_last = last_addr_bit(next_shift_in[7:0],
                                                       bank_reg[BANK_EXT_BIT]);
                        case (next_shift_in[7:0])
                            OP_READ_3B, OP_READ_4B: begin
                                next_addr_space = SPACE_MAIN;
                                next_state = ST_ADDR;
                            end
                            OP_OTP_READ: begin
                                next_addr_space = SPACE_OTP;
                                next_state = ST_ADDR;
                            end
                            OP_BANK_WRITE: begin
                                next_state = ST_BANK_WR;
                            end
                            OP_BANK_READ: begin
                                next_shift_out = bank_reg;
                                next_state = ST_BANK_RD;
                            end
                            OP_READ_ID: begin
                                // no address field; the id space starts at 0
                                next_addr_space = SPACE_ID;
                                next_eff_addr = 32'h0000_0000;
                                next_addr_valid = 1'b1;
                                next_state = ST_REST;
                            end
                            default: begin
                                next_state = ST_REST;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (bit_cnt == addr_last) begin
                        if (addr_last == LAST_BIT_3B) begin
                            // bank fills bits 30..24, bit 31 stays clear
                            next_eff_addr = {1'b0,
                                bank_reg[BANK_HI_MSB:0],
                                next_shift_in[23:0]};
                        end else begin
                            next_eff_addr = next_shift_in;
                        end
                        if (small_s && addr_space == SPACE_MAIN) begin
                            next_eff_addr[31:24] = 8'h00;
                        end
                        next_addr_valid = 1'b1;
                        next_state = ST_REST;
                    end
                end
                ST_BANK_WR: begin
                    if (bit_cnt == LAST_BIT_BYTE) begin
                        next_bank_reg = next_shift_in[7:0];
                        next_state = ST_REST;
                    end
                end
                ST_BANK_RD, ST_REST: begin
                    // counter wraps harmlessly; nothing reads it here
                end
                default: begin
                    next_state = ST_REST;
                end
            endcase
        end else if (sck_fall && state == ST_BANK_RD) begin
            // repeats the bank byte for as long as the host clocks
            next_so = shift_out[7];
            next_shift_out = {shift_out[6:0], shift_out[7]};
            next_so_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_CMD;
            bit_cnt <= 6'h00;
            shift_in <= 32'h0000_0000;
            shift_out <= 8'h00;
            addr_last <= LAST_BIT_3B;
            addr_space <= SPACE_MAIN;
            bank_reg <= BANK_RESET;
            addr_valid <= 1'b0;
            eff_addr <= 32'h0000_0000;
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            addr_last <= next_addr_last;
            addr_space <= next_addr_space;
            bank_reg <= next_bank_reg;
            addr_valid <= next_addr_valid;
            eff_addr <= next_eff_addr;
            so <= next_so;
            so_oe_n <= next_so_oe_n;
        end
    end

endmodule : fea_addr

//--- verif/fea_addr_assertions.sv
/* checker for the address former's port timing.
   assumes fea_addr ports and fea_pkg; bound below. */
`timescale 1ns/1ps
module fea_addr_assertions
    import fea_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic small_density,
    input wire logic so_oe_n,
    input wire logic addr_valid,
    input wire logic [31:0] eff_addr,
    input wire logic [1:0] addr_space,
    input wire logic [7:0] bank_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_clear_a: assert property ($rose(rst_n) |->
        bank_reg == BANK_RESET && so_oe_n) else $error("bank not cleared");
    valid_pulse_a: assert property (addr_valid |=> !addr_valid)
        else $error("strobe too long");
    eff_hold_a: assert property (!addr_valid |-> $stable(eff_addr))
        else $error("address moved without strobe");
    valid_framed_a: assert property (addr_valid |-> !$past(cs_n, 4))
        else $error("strobe outside frame");
    main_mask_a: assert property (addr_valid && small_density &&
        addr_space == SPACE_MAIN |-> eff_addr[31:24] == 8'h00)
        else $error("top byte kept");
    id_space_a: assert property (addr_valid &&
        addr_space == SPACE_ID |-> eff_addr == 32'h0) else $error("id addr");
    bank_framed_a: assert property (!$stable(bank_reg) |->
        !$past(cs_n, 4)) else $error("bank moved outside frame");
    drive_framed_a: assert property (!so_oe_n |-> !$past(cs_n, 5))
        else $error("output driven outside frame");
    space_legal_a: assert property (addr_valid |-> addr_space != 2'h3)
        else $error("bad space");
endmodule : fea_addr_assertions
bind fea_addr fea_addr_assertions i_chk (.clk, .rst_n, .cs_n, .small_density,
    .so_oe_n, .addr_valid, .eff_addr, .addr_space, .bank_reg);

//--- verif/fea_host_model.sv
/* host serial controller model sending mode 0 frames.
   assumes a free clk; sck half period is four clk, still between frames. */
`timescale 1ns/1ps
module fea_host_model (
    // system clock
    input wire logic clk,
    // serial link
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    // rd keeps the last eight driven so samples, cleared while undriven
    task automatic xfer(input logic [39:0] bits, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            repeat (4) @(negedge clk);
            rd = so_oe_n ? 8'h00 : {rd[6:0], so};
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        si = ~si; // released line must not look stable
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : fea_host_model

//--- verif/fea_addr_tb.sv
/* self-checking bench for the address former.
   assumes fea_pkg, the host model, and a 50 MHz clk. */
`timescale 1ns/1ps
module fea_addr_tb;
    import fea_pkg::*;
    logic clk, rst_n, sck, cs_n, si, so, so_oe_n, small_density, addr_valid;
    logic [31:0] eff_addr, got_addr;
    logic [1:0] addr_space, got_sp;
    logic [7:0] bank_reg, bank, rd;
    int err_count = 0, samples_checked = 0, nvalid = 0;
    fea_addr i_dut (.clk, .rst_n, .sck, .cs_n, .si, .so, .so_oe_n,
        .small_density, .addr_valid, .eff_addr, .addr_space, .bank_reg);
    fea_host_model i_host (.clk, .sck, .cs_n, .si, .so, .so_oe_n);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (addr_valid) begin
            got_addr <= eff_addr;
            got_sp <= addr_space;
            nvalid <= nvalid + 1;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    function automatic logic [31:0] exp_addr(logic [7:0] op, logic [31:0] a);
        logic [31:0] e;
        e = a;
        if (op == OP_READ_3B && !bank[BANK_EXT_BIT]) begin
            e = {1'b0, bank[BANK_HI_MSB:0], a[23:0]};
        end
        if (small_density && op != OP_OTP_READ) e[31:24] = 8'h00;
        return e;
    endfunction : exp_addr
    task automatic run_cmd(input logic [7:0] op, input logic [31:0] a);
        int n0, nb;
        logic [39:0] bits;
        n0 = nvalid;
        nb = (op == OP_READ_3B && !bank[BANK_EXT_BIT]) ? 3 : 4;
        bits = (nb == 3) ? {8'h00, op, a[23:0]} : {op, a};
        if (op == OP_READ_ID) nb = 0;
        if (op == OP_READ_ID) bits = {32'h0, op};
        i_host.xfer(bits, 8 + 8 * nb, rd);
        check(32'(nvalid - n0), 32'h1);
        check(got_addr, op == OP_READ_ID ? 32'h0 : exp_addr(op, a));
        check({30'h0, got_sp}, {30'h0, op == OP_READ_ID ? SPACE_ID :
            op == OP_OTP_READ ? SPACE_OTP : SPACE_MAIN});
    endtask : run_cmd
    // n below 16 cuts the write short
    task automatic bank_wr(input logic [7:0] v, input int n);
        i_host.xfer({24'h0, OP_BANK_WRITE, v} >> (16 - n), n, rd);
        if (n == 16) bank = v;
        check({24'h0, bank_reg}, {24'h0, bank});
        i_host.xfer({24'h0, OP_BANK_READ, 8'h00}, 16, rd);
        check({24'h0, rd}, {24'h0, bank});
    endtask : bank_wr
    // frames that must leave no trace: unknown opcode, cut address
    task automatic run_void(input logic [7:0] op);
        int n0;
        n0 = nvalid;
        i_host.xfer({op, 32'($urandom)}, 40, rd);
        i_host.xfer({16'h0, OP_READ_4B, 16'h1234}, 24, rd);
        check(32'(nvalid - n0), 32'h0);
        check(eff_addr, got_addr);
        check({24'h0, bank_reg}, {24'h0, bank});
    endtask : run_void
    initial begin
        rst_n = 1'b0;
        small_density = 1'b0;
        bank = BANK_RESET;
        void'($urandom(39));
        for (int r = 0; r < 2; r++) begin
            rst_n = 1'b0;
            // posedges only: the clock's first step from unknown is no count
            repeat (3) @(posedge clk);
            @(negedge clk);
            rst_n = 1'b1;
            repeat (8) @(negedge clk);
            bank = BANK_RESET;
            check({24'h0, bank_reg}, {24'h0, BANK_RESET});
            run_cmd(OP_READ_3B, $urandom);
            run_cmd(OP_READ_ID, 32'h0);
            run_void(8'h5a);
            bank_wr(8'h7f, 16);
            run_cmd(OP_READ_3B, 32'hffffffff);
            bank_wr(8'h2a, 12);
            bank_wr(8'h85, 16);
            run_cmd(OP_READ_3B, $urandom);
        end
        for (int k = 0; k < 18; k++) begin
            small_density = 1'($urandom);
            if (k % 4 == 0) bank_wr(8'($urandom), 16);
            run_cmd(k % 3 == 0 ? OP_READ_3B : k % 3 == 1 ? OP_READ_4B :
                OP_OTP_READ, $urandom);
        end
        finish_test();
    end
endmodule : fea_addr_tb
